// ### src/sdor_pkg.sv
/*
  Package for the sigma-delta overload recovery block: widths, full-scale codes,
  sequence lengths and feedback current scaling.
  Assumes a single modulator-rate clock; no software-visible registers.
*/
package sdor_pkg;
  localparam int QUANT_W = 5;
  localparam logic [QUANT_W-1:0] CODE_POS_FS = 5'h0F;
  localparam logic [QUANT_W-1:0] CODE_NEG_FS = 5'h10;
  localparam int WINDOW_LEN = 8;
  localparam int HIT_LIMIT = 5;
  localparam int RESET_CYCLES = 16;
  localparam int RESTORE_CYCLES = 48;
  localparam int RECOVER_CYCLES = RESET_CYCLES + RESTORE_CYCLES;
  localparam logic [5:0] BOOST_DB = 6'h06;
  localparam int STEP_CYCLES = RESTORE_CYCLES / 6;
  localparam int ATTEN_W = 6;
  localparam int CODE_W = 7;
  localparam logic [CODE_W-1:0] CODE_FULL = 7'h40;
  localparam logic [CODE_W-1:0] CODE_MIN = 7'h10;
  localparam logic [CODE_W-1:0] CODE_RESET = 7'h40;
  localparam logic [7:0] HALF_UA_PER_CODE = 8'h7D;
  localparam int CURRENT_W = 14;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  typedef enum logic [2:0]
  {
    SDOR_IDLE = 3'b001,
    SDOR_LOOP_RESET = 3'b010,
    SDOR_RESTORE = 3'b100
  } sdor_state_t;
endpackage : sdor_pkg

// ### src/sdor_det_if.sv
/*
  Carrier between the recovery controller and its overload detector.
  Assumes both ends run on the same modulator clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdor_det_if;
  logic [sdor_pkg::QUANT_W-1:0] code;
  logic overload;
  modport det (input code, output overload);
  modport ctl (output code, input overload);
endinterface : sdor_det_if
`default_nettype wire

// ### src/sdor_detector.sv
/*
  Overload detector: sliding window of the latest quantizer samples, flags a
  declared overload as a one-cycle pulse.
  Assumes one quantizer code per clock, driven from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdor_detector
(
  input wire logic clk_sys,
  input wire logic reset,
  sdor_det_if.det det
);
  import sdor_pkg::*;

  logic [WINDOW_LEN-1:0] hits;
  logic [WINDOW_LEN-1:0] next_hits;
  logic overload;
  logic next_overload;
  logic [3:0] count;
  logic is_fs;

  always_comb
  begin
    is_fs = (det.code == CODE_POS_FS) || (det.code == CODE_NEG_FS);
    next_hits = {hits[WINDOW_LEN-2:0], is_fs};
    count = 4'h0;
    for (int i = 0; i < WINDOW_LEN; i++)
    begin
      count = count + {3'h0, next_hits[i]};
    end
    next_overload = (count > 4'(HIT_LIMIT));
    // The window is emptied once an overload is declared, since the loop is being
    // reset and the old samples no longer describe it.
    if (next_overload)
    begin
      next_hits = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      hits <= '0;
      overload <= 1'b0;
    end
    else
    begin
      hits <= next_hits;
      overload <= next_overload;
    end
  end

  assign det.overload = overload;
endmodule : sdor_detector
`default_nettype wire

// ### src/sdor_recovery.sv
/*
  Sigma-delta overload recovery controller: detects quantizer overload, resets
  the modulator loop, boosts the attenuation and walks it back, and scales the
  full-scale feedback current code.
  Assumes quant_code and the settings come from logic on clk_sys (modulator clock).
  The current code and base attenuation are plain levels from configuration logic
  elsewhere; the block holds no software-visible registers of its own.
  The decimation filters that must flush data taken during an overload lie outside,
  and samples_valid only tells them when the modulator output is trustworthy again.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - The detector compares 5-bit quantizer codes against the most positive and most negative codes.
// - Overload is declared when more than five of eight consecutive samples are full scale.
// - On overload the loop state is forced to zero and the attenuation is raised by 6 dB.
// - The loop reset is held for 16 modulator cycles after detection and then released.
// - After release the attenuation steps back to its original value over 48 cycles.
// - A new overload restarts the whole reset and attenuation sequence.
// - Samples are flagged valid again within 64 cycles once the input is back in range.
// - The full-scale feedback current is 4 mA times the code over 64, from 4 mA down to 1 mA.
module sdor_recovery
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [sdor_pkg::QUANT_W-1:0] quant_code,
  input wire logic [sdor_pkg::ATTEN_W-1:0] base_atten_db,
  input wire logic [sdor_pkg::CODE_W-1:0] feedback_current_code,
  output logic loop_reset,
  output logic [sdor_pkg::ATTEN_W-1:0] atten_db,
  output logic samples_valid,
  output logic overload_event,
  output logic [sdor_pkg::CURRENT_W-1:0] feedback_current_half_ua
);
  import sdor_pkg::*;

  // The detector sits on its own carrier so that its window logic can be replaced
  // without touching the sequence controller.
  sdor_det_if det_bus ();

  sdor_state_t state;
  sdor_state_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] boost;
  logic [ATTEN_W-1:0] next_atten_db;
  logic [CODE_W-1:0] code_clamped;
  logic [CURRENT_W-1:0] next_current;
  logic next_loop_reset;
  logic next_samples_valid;
  logic next_overload_event;

  assign det_bus.code = quant_code;

  sdor_detector u_det
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .det(det_bus.det)
  );

  // Sequence timeline, counted from the edge that registers the detector's pulse:
  // RESET_CYCLES edges of loop reset with the full boost, then RESTORE_CYCLES edges
  // in which the boost drops by one decibel every STEP_CYCLES, then idle.
  // The counter restarts from zero at each change of state, so six bits cover the
  // longest phase; a detection in any phase starts again at the first, which is
  // what keeps a stubborn overload from being released half-way.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      SDOR_IDLE:
      begin
        next_cnt = CNT_ZERO;
      end
      SDOR_LOOP_RESET:
      begin
        if (cnt == 6'(RESET_CYCLES - 1))
        begin
          next_state = SDOR_RESTORE;
          next_cnt = CNT_ZERO;
        end
        else
        begin
          next_cnt = cnt + 6'h01;
        end
      end
      SDOR_RESTORE:
      begin
        if (cnt == 6'(RESTORE_CYCLES - 1))
        begin
          next_state = SDOR_IDLE;
          next_cnt = CNT_ZERO;
        end
        else
        begin
          next_cnt = cnt + 6'h01;
        end
      end
      default:
      begin
        next_state = SDOR_IDLE;
        next_cnt = CNT_ZERO;
      end
    endcase
    // Detection takes priority over any step of a sequence already under way,
    // since the loop may have gone unstable again before the boost was gone.
    if (det_bus.overload)
    begin
      next_state = SDOR_LOOP_RESET;
      next_cnt = CNT_ZERO;
    end
  end

  // The boost follows next_state, so atten_db moves on the same edge as
  // loop_reset instead of one cycle behind it.
  always_comb
  begin
    boost = 6'h00;
    if (next_state == SDOR_LOOP_RESET)
    begin
      boost = BOOST_DB;
    end
    else if (next_state == SDOR_RESTORE)
    begin
      // One decibel comes off every eighth cycle of the restore phase.
      boost = BOOST_DB - 6'(next_cnt / 6'(STEP_CYCLES));
    end
    next_atten_db = base_atten_db + boost;
  end

  // A base setting near the top of the attenuator span wraps when boosted; the
  // configuration side is expected to keep base_atten_db within that span.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      atten_db <= '0;
    end
    else
    begin
      atten_db <= next_atten_db;
    end
  end

  always_comb
  begin
    // Codes outside the span are clamped so the current never leaves 1..4 mA.
    if (feedback_current_code > CODE_FULL)
    begin
      code_clamped = CODE_FULL;
    end
    else if (feedback_current_code < CODE_MIN)
    begin
      code_clamped = CODE_MIN;
    end
    else
    begin
      code_clamped = feedback_current_code;
    end
    // 4 mA / 64 is 62.5 uA per code step, kept exact in half-microamp units.
    // Both factors are widened first so the product keeps all thirteen bits.
    next_current = CURRENT_W'(code_clamped) * CURRENT_W'(HALF_UA_PER_CODE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      feedback_current_half_ua <= CURRENT_W'(CODE_RESET) * CURRENT_W'(HALF_UA_PER_CODE);
    end
    else
    begin
      feedback_current_half_ua <= next_current;
    end
  end

  // overload_event repeats the detector's pulse on the edge that starts the
  // sequence, so the pulse marks the first cycle of loop reset.
  always_comb
  begin
    next_loop_reset = (next_state == SDOR_LOOP_RESET);
    next_samples_valid = (next_state == SDOR_IDLE);
    next_overload_event = det_bus.overload;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      loop_reset <= 1'b0;
      samples_valid <= 1'b1;
      overload_event <= 1'b0;
    end
    else
    begin
      loop_reset <= next_loop_reset;
      samples_valid <= next_samples_valid;
      overload_event <= next_overload_event;
    end
  end

  // State and counter are cleared together, so a reset in mid-sequence leaves no
  // partial count for the next detection to inherit.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state <= SDOR_IDLE;
      cnt <= CNT_ZERO;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end
endmodule : sdor_recovery
`default_nettype wire

// ### tb/sdor_assertions.sv
/* Port checker for sdor_recovery.
   Assumes a single clk_sys domain and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module sdor_assertions
  import sdor_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [4:0] quant_code,
  input wire logic [5:0] base_atten_db,
  input wire logic [6:0] feedback_current_code,
  input wire logic loop_reset,
  input wire logic [5:0] atten_db,
  input wire logic samples_valid,
  input wire logic overload_event,
  input wire logic [13:0] feedback_current_half_ua
);
  logic [6:0] n;
  logic [6:0] next_n;
  logic [7:0] fs;
  logic [7:0] next_fs;
  logic [5:0] bst;
  logic [13:0] cur;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // The age n saturates so a long idle spell never wraps back into the sequence.
  always_comb
  begin
    next_fs = {fs[6:0], quant_code == CODE_POS_FS || quant_code == CODE_NEG_FS};
    next_n = reset ? 7'h00 : overload_event ? 7'h01 : (n != 7'h00 && n < 7'h64) ? n + 7'h01 : n;
    bst = n < 7'h10 ? 6'h06 : n >= 7'h40 ? 6'h00 : 6'h06 - 6'((n - 7'h10) >> 3);
    cur = feedback_current_code > 7'h40 ? 14'h1F40 :
      feedback_current_code < 7'h10 ? 14'h07D0 : 14'(feedback_current_code) * 14'h7D;
  end
  always_ff @(posedge clk_sys)
  begin
    n <= next_n;
    fs <= next_fs;
  end
  chk_event_pulse: assert property (overload_event |=> !overload_event)
    else $error("overload_event wider than one cycle");
  chk_event_start: assert property (overload_event |-> loop_reset && !samples_valid
    && atten_db == $past(base_atten_db) + BOOST_DB) else $error("bad sequence start");
  chk_reset_len: assert property (n != 0 && !overload_event |-> loop_reset == (n < 16))
    else $error("loop_reset length wrong");
  chk_atten_walk: assert property (n != 0 && !overload_event |->
    atten_db == $past(base_atten_db) + bst) else $error("attenuation walk wrong");
  chk_valid_gap: assert property (n != 0 && !overload_event |-> samples_valid == (n >= 64))
    else $error("samples_valid timing wrong");
  chk_needs_six: assert property (overload_event |-> $countones($past(fs)) >= 6)
    else $error("overload without six full-scale samples");
  chk_quiet_none: assert property (fs[2:0] == 3'h0 |=> !overload_event)
    else $error("overload after non full-scale samples");
  chk_current_scale: assert property (!$past(reset) |-> feedback_current_half_ua == $past(cur))
    else $error("feedback current wrong");
endmodule : sdor_assertions
bind sdor_recovery sdor_assertions u_chk (.clk_sys, .reset, .quant_code, .base_atten_db,
  .feedback_current_code, .loop_reset, .atten_db, .samples_valid, .overload_event,
  .feedback_current_half_ua);
`default_nettype wire

// ### tb/test_sigma_delta_overload_recovery.sv
/* Self-checking bench for sdor_recovery.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_sigma_delta_overload_recovery;
  import sdor_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [4:0] quant_code = 5'h00;
  logic [5:0] base_atten_db = 6'h05;
  logic [6:0] feedback_current_code = 7'h40;
  logic loop_reset;
  logic [5:0] atten_db;
  logic samples_valid;
  logic overload_event;
  logic [13:0] feedback_current_half_ua;
  logic [6:0] codes [8] = '{7'h00, 7'h0F, 7'h10, 7'h20, 7'h40, 7'h41, 7'h7F, 7'h2B};
  logic [31:0] seed = 32'h363E;
  int n_fail = 0;
  int compares = 0;
  int age = 1000;
  always #5 clk_sys = ~clk_sys;
  sdor_recovery dut (.clk_sys, .reset, .quant_code, .base_atten_db, .feedback_current_code,
    .loop_reset, .atten_db, .samples_valid, .overload_event, .feedback_current_half_ua);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [13:0] exp_cur(logic [6:0] c);
    return c > 7'h40 ? 14'h1F40 : c < 7'h10 ? 14'h07D0 : 14'(c) * 14'h7D;
  endfunction : exp_cur
  // Boost k cycles after the sequence starts: full during loop reset, then one
  // decibel less every STEP_CYCLES until the recovery is over.
  function automatic logic [5:0] exp_boost(int k);
    return k < RESET_CYCLES ? BOOST_DB : k >= RECOVER_CYCLES ? 6'h00 :
      BOOST_DB - 6'((k - RESET_CYCLES) / STEP_CYCLES);
  endfunction : exp_boost
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic do_reset();
    reset = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("loop_reset", loop_reset, 0);
    check("samples_valid", samples_valid, 1);
    check("current", feedback_current_half_ua, 14'h1F40);
    check("atten_db", atten_db, 6'h00);
    check("overload_event", overload_event, 1'b0);
    reset = 1'b0;
  endtask : do_reset
  // Six alternating full-scale codes, then the recovery walk is followed for len cycles.
  task automatic overload(int len);
    for (int k = 0; k < 6; k++)
      @(negedge clk_sys) quant_code = k[0] ? CODE_NEG_FS : CODE_POS_FS;
    @(negedge clk_sys) quant_code = 5'h00;
    @(negedge clk_sys);
    check("overload_event", overload_event, 1);
    for (int k = 0; k < len; k++)
    begin
      check("loop_reset", loop_reset, k < 16);
      check("atten_db", atten_db, base_atten_db + exp_boost(k));
      check("samples_valid", samples_valid, k >= 64);
      @(negedge clk_sys);
    end
  endtask : overload
  initial
  begin
    do_reset();
    foreach (codes[i])
    begin
      @(negedge clk_sys) feedback_current_code = codes[i];
      @(negedge clk_sys);
      check("current", feedback_current_half_ua, exp_cur(codes[i]));
    end
    $display("test current done");
    overload(80);
    $display("test sequence done");
    overload(30);
    overload(80);
    $display("test restart done");
    // Exactly five full-scale codes in every eight must never trip the detector.
    for (int k = 0; k < 48; k++)
    begin
      @(negedge clk_sys) quant_code = k % 8 < 5 ? CODE_POS_FS : 5'h03;
      check("overload_event", overload_event, 0);
    end
    $display("test five of eight done");
    // The age counts cycles since the last overload_event, so every restart of the
    // sequence under random stimulus is checked against the same walk.
    repeat (600)
    begin
      @(negedge clk_sys);
      age = overload_event ? 0 : age + 1;
      check("current", feedback_current_half_ua, exp_cur(feedback_current_code));
      check("loop_reset", loop_reset, age < 16);
      check("atten_db", atten_db, base_atten_db + exp_boost(age));
      check("samples_valid", samples_valid, age >= 64);
      seed = rnd();
      quant_code = seed[1] ? (seed[0] ? CODE_POS_FS : CODE_NEG_FS) : seed[6:2];
      base_atten_db = {1'b0, seed[12:8]};
      feedback_current_code = seed[22:16];
    end
    $display("test random done");
    @(negedge clk_sys) quant_code = 5'h00;
    do_reset();
    @(negedge clk_sys);
    check("atten_db", atten_db, base_atten_db);
    overload(70);
    $display("test reset done");
    results();
  end
endmodule : test_sigma_delta_overload_recovery
`default_nettype wire
